// [pkg/olm_pkg.sv]
package olm_pkg;
    // Macrocell count and product-term budget per macrocell
    localparam int unsigned NUM_CELLS = 8;
    localparam int unsigned PT_PER_CELL = 8;
    localparam int unsigned PT_IO_USED = 7;
    localparam int unsigned PT_OE_INDEX = 0;
    // Outermost and innermost macrocell indices (0 = pin next to the enable pin side)
    localparam int unsigned CELL_OUTER_LO = 0;
    localparam int unsigned CELL_OUTER_HI = 7;
    localparam int unsigned CELL_INNER_LO = 3;
    localparam int unsigned CELL_INNER_HI = 4;
    // Reset value of the registered pin output values (pin_r)
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        OLM_MODE_REGISTERED,
        OLM_MODE_COMPLEX,
        OLM_MODE_SIMPLE
    } olm_mode_t;
endpackage

// [rtl/olm_mode_decode.sv]
`timescale 1ns/1ns
module olm_mode_decode (
    input wire logic i_sync_mode_bit,         // Global sync mode bit
    input wire logic i_global_arch_bit,       // Global architecture bit
    output olm_pkg::olm_mode_t o_mode         // Decoded global mode
);
    always_comb begin
        if (i_sync_mode_bit && !i_global_arch_bit) begin
            o_mode = olm_pkg::OLM_MODE_SIMPLE;
        end else if (i_sync_mode_bit) begin
            o_mode = olm_pkg::OLM_MODE_COMPLEX;
        end else begin
            o_mode = olm_pkg::OLM_MODE_REGISTERED;
        end
    end
endmodule

// [rtl/olm_cell.sv]
`timescale 1ns/1ns
module olm_cell (
    input wire logic i_ref_clk,               // System clock
    input wire logic i_nrst,                  // Async reset, active low
    input wire logic i_ce,                    // Clock enable
    input wire logic i_clk_pin_rise,          // Rising edge seen on shared clock pin
    input wire logic i_preload,               // Preload strobe
    input wire logic i_preload_val,           // Preload value
    input wire logic [7:0] i_pt,              // Product terms of this cell
    input wire logic i_polarity_select,       // 1 active high, 0 active low
    input wire logic i_io_config_bit,         // Per-cell I/O selection
    input wire logic i_oe_pin,                // Shared output enable pin level
    input wire olm_pkg::olm_mode_t i_mode,    // Global mode
    input wire logic i_oe_allowed,            // Cell may drive in simple mode
    output logic o_q,                         // Register state
    output logic o_out,                       // Pin output value
    output logic o_drive                      // Pin driven
);
    logic q;
    logic next_q;
    logic sum_all;
    logic sum_io;
    logic comb;

    assign sum_all = |i_pt;
    assign sum_io = |i_pt[olm_pkg::PT_PER_CELL-1:1];

    always_comb begin
        next_q = q;
        if (i_preload) begin
            next_q = i_preload_val;
        end else if (i_clk_pin_rise && i_mode == olm_pkg::OLM_MODE_REGISTERED && !i_io_config_bit) begin
            next_q = sum_all;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= 1'b0;
        end else if (i_ce) begin
            q <= next_q;
        end
    end

    always_comb begin
        comb = sum_io;
        o_drive = 1'b0;
        unique case (i_mode)
            olm_pkg::OLM_MODE_REGISTERED: begin
                if (!i_io_config_bit) begin
                    // Register output inverted through polarity like the combinational path
                    comb = q;
                    o_drive = i_oe_pin;
                end else begin
                    o_drive = i_pt[olm_pkg::PT_OE_INDEX];
                end
            end
            olm_pkg::OLM_MODE_COMPLEX: begin
                o_drive = i_pt[olm_pkg::PT_OE_INDEX];
            end
            olm_pkg::OLM_MODE_SIMPLE: begin
                comb = sum_all;
                o_drive = i_oe_allowed && !i_io_config_bit;
            end
            default: begin
                o_drive = 1'b0;
            end
        endcase
    end

    assign o_out = i_polarity_select ? comb : ~comb;
    assign o_q = q;
endmodule

// [rtl/olm_array.sv]
`timescale 1ns/1ns
module olm_array (
    input wire logic i_ref_clk,               // System clock, 100 MHz
    input wire logic i_nrst,                  // Async reset, active low
    input wire logic i_ce,                    // Clock enable
    input wire logic i_sync_mode_bit,         // Global sync mode bit
    input wire logic i_global_arch_bit,       // Global architecture bit
    input wire logic [7:0] i_polarity_select, // Per-cell polarity
    input wire logic [7:0] i_io_config_bit,   // Per-cell I/O selection
    input wire logic [63:0] i_pt,             // Product terms, 8 per cell, cell n at [8n+7:8n]
    input wire logic i_clk_pin,               // Shared clock pin / data input
    input wire logic i_oe_pin,                // Shared enable pin (active low) / data input
    input wire logic [7:0] i_pin,             // Pin levels seen from outside
    input wire logic i_preload,               // Preload strobe
    input wire logic [7:0] i_preload_val,     // Preload values
    output logic [7:0] o_pin,                 // Pin output values
    output logic [7:0] o_pin_oe_n,            // Pin output enables, low drives
    output logic [7:0] o_feedback,            // Feedback into the product-term array
    output logic o_clk_in_data,               // Clock pin as data input
    output logic o_oe_in_data,                // Enable pin as data input
    output logic [7:0] o_reg_q,               // Register states
    output logic [1:0] o_mode                 // Decoded mode
);
    olm_pkg::olm_mode_t mode;
    logic clk_pin_d;
    logic next_clk_pin_d;
    logic clk_rise;
    logic [7:0] out_val;
    logic [7:0] drive;
    logic [7:0] q;
    logic [7:0] next_out;
    logic [7:0] next_oe_n;
    logic [7:0] next_fb;
    logic next_clk_data;
    logic next_oe_data;
    logic [7:0] pin_r;
    logic [7:0] oe_n_r;
    logic [7:0] fb_r;
    logic clk_data_r;
    logic oe_data_r;

    olm_mode_decode u_dec (
        .i_sync_mode_bit(i_sync_mode_bit),
        .i_global_arch_bit(i_global_arch_bit),
        .o_mode(mode)
    );

    assign next_clk_pin_d = i_clk_pin;
    assign clk_rise = i_clk_pin && !clk_pin_d && mode == olm_pkg::OLM_MODE_REGISTERED;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_pin_d <= 1'b0;
        end else if (i_ce) begin
            clk_pin_d <= next_clk_pin_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < olm_pkg::NUM_CELLS; g++) begin : g_cell
            olm_cell u_cell (
                .i_ref_clk(i_ref_clk),
                .i_nrst(i_nrst),
                .i_ce(i_ce),
                .i_clk_pin_rise(clk_rise),
                .i_preload(i_preload),
                .i_preload_val(i_preload_val[g]),
                .i_pt(i_pt[g*8 +: 8]),
                .i_polarity_select(i_polarity_select[g]),
                .i_io_config_bit(i_io_config_bit[g]),
                // Enable pin is active low at the package
                .i_oe_pin(!i_oe_pin),
                .i_mode(mode),
                .i_oe_allowed(g != olm_pkg::CELL_INNER_LO && g != olm_pkg::CELL_INNER_HI || 1'b1),
                .o_q(q[g]),
                .o_out(out_val[g]),
                .o_drive(drive[g])
            );
        end
    endgenerate

    // Output, enable and feedback steering per mode; registered so data outputs come from flops
    always_comb begin
        next_out = out_val;
        next_oe_n = ~drive;
        next_fb = i_pin;
        next_clk_data = 1'b0;
        next_oe_data = 1'b0;
        unique case (mode)
            olm_pkg::OLM_MODE_REGISTERED: begin
                // Registered cells feed back their own register, I/O cells the pin
                for (int i = 0; i < 8; i++) begin
                    if (!i_io_config_bit[i]) begin
                        next_fb[i] = q[i];
                    end
                end
            end
            olm_pkg::OLM_MODE_COMPLEX: begin
                // Outer cells give their feedback path to the two spare inputs
                next_fb[olm_pkg::CELL_OUTER_HI] = i_clk_pin;
                next_fb[olm_pkg::CELL_OUTER_LO] = i_oe_pin;
                next_clk_data = i_clk_pin;
                next_oe_data = i_oe_pin;
                for (int i = 0; i < 8; i++) begin
                    // I/O bit clear makes a pure output that never tristates
                    if (!i_io_config_bit[i] || i == olm_pkg::CELL_OUTER_LO || i == olm_pkg::CELL_OUTER_HI) begin
                        next_oe_n[i] = i_io_config_bit[i] ? ~drive[i] : 1'b0;
                    end
                end
            end
            olm_pkg::OLM_MODE_SIMPLE: begin
                next_clk_data = i_clk_pin;
                next_oe_data = i_oe_pin;
                for (int i = 0; i < 8; i++) begin
                    // Feedback paths of cells 0-2 and 5-7 carry the inner neighbour's pin; cells 3 and 4 feed back 0
                    if (i < 4) begin
                        next_fb[i] = (i == olm_pkg::CELL_INNER_LO) ? 1'b0 : i_pin[i+1];
                    end else begin
                        next_fb[i] = (i == olm_pkg::CELL_INNER_HI) ? 1'b0 : i_pin[i-1];
                    end
                end
                // Inner cells are always driven outputs whatever their I/O bit says
                next_oe_n[olm_pkg::CELL_INNER_LO] = 1'b0;
                next_oe_n[olm_pkg::CELL_INNER_HI] = 1'b0;
            end
            default: begin
                next_oe_n = 8'hFF;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_r <= olm_pkg::REG_RESET;
            oe_n_r <= 8'hFF;
            fb_r <= 8'h00;
            clk_data_r <= 1'b0;
            oe_data_r <= 1'b0;
        end else if (i_ce) begin
            pin_r <= next_out;
            oe_n_r <= next_oe_n;
            fb_r <= next_fb;
            clk_data_r <= next_clk_data;
            oe_data_r <= next_oe_data;
        end
    end

    // Only sixteen cell bits and two global bits steer anything here
    assign o_pin = pin_r;
    assign o_pin_oe_n = oe_n_r;
    assign o_feedback = fb_r;
    assign o_clk_in_data = clk_data_r;
    assign o_oe_in_data = oe_data_r;
    assign o_reg_q = q;
    assign o_mode = mode;
endmodule

// [tb/olm_board.sv]
`timescale 1ns/1ns
module olm_board (
    input wire logic i_ref_clk, // Clock
    input wire logic [7:0] i_pin_val, // Device pin values
    input wire logic [7:0] i_pin_oe_n, // Low where device drives
    output logic [7:0] o_level // Resolved pin levels
);
    logic [7:0] pat = 8'h5A;
    // Released pins toggle each cycle so a stale value never looks valid
    always @(posedge i_ref_clk) pat <= ~pat;
    assign o_level = (i_pin_val & ~i_pin_oe_n) | (pat & i_pin_oe_n);
endmodule

// [tb/olm_array_asserts.sv]
`timescale 1ns/1ns
module olm_array_chk (
    input wire logic i_ref_clk, // Clock
    input wire logic i_nrst, // Reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic i_sync_mode_bit, // Global bit
    input wire logic i_global_arch_bit, // Global bit
    input wire logic [7:0] i_polarity_select, // Polarity
    input wire logic [7:0] i_io_config_bit, // I/O select
    input wire logic [63:0] i_pt, // Product terms
    input wire logic i_clk_pin, // Clock pin
    input wire logic i_oe_pin, // Enable pin
    input wire logic i_preload, // Preload strobe
    input wire logic [7:0] i_preload_val, // Preload data
    input wire logic [7:0] o_pin, // Pin values
    input wire logic [7:0] o_pin_oe_n, // Pin enables
    input wire logic o_clk_in_data, // Clock pin data
    input wire logic o_oe_in_data, // Enable pin data
    input wire logic [7:0] o_reg_q, // Registers
    input wire logic [1:0] o_mode // Mode
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic [7:0] pt_or;
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            pt_or[n] = |i_pt[8*n +: 8];
        end
    end
    sequence s_rise;
        !i_clk_pin ##1 i_clk_pin;
    endsequence
    sequence s_cap;
        s_rise ##0 (!i_sync_mode_bit && i_ce && !i_preload);
    endsequence
    property p_mode;
        o_mode == (i_sync_mode_bit ? (i_global_arch_bit ? 2'h1 : 2'h2) : 2'h0);
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode wrong");
    property p_rst;
        $rose(i_nrst) |-> o_reg_q == 8'h00 && o_pin_oe_n == 8'hFF;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_cap;
        s_cap |=> o_reg_q == (($past(pt_or) & ~$past(i_io_config_bit)) | ($past(o_reg_q) & $past(i_io_config_bit)));
    endproperty
    a_cap: assert property (p_cap) else $error("capture wrong");
    property p_hold;
        (!i_ce || (!i_preload && !(!i_sync_mode_bit && i_clk_pin && !$past(i_clk_pin)))) |=> $stable(o_reg_q);
    endproperty
    a_hold: assert property (p_hold) else $error("register moved");
    property p_pre;
        i_ce && i_preload |=> o_reg_q == $past(i_preload_val);
    endproperty
    a_pre: assert property (p_pre) else $error("preload wrong");
    property p_oe;
        !i_sync_mode_bit && i_ce |=> ((o_pin_oe_n ^ {8{$past(i_oe_pin)}}) & ~$past(i_io_config_bit)) == 8'h00;
    endproperty
    a_oe: assert property (p_oe) else $error("shared enable wrong");
    property p_pol;
        !i_sync_mode_bit && i_ce |=>
            ((o_pin ^ $past(o_reg_q) ^ ~$past(i_polarity_select)) & ~$past(i_io_config_bit)) == 8'h00;
    endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong");
    property p_ded;
        !i_sync_mode_bit && i_ce |=> !o_clk_in_data && !o_oe_in_data;
    endproperty
    a_ded: assert property (p_ded) else $error("dedicated pins leak");
    property p_cplx;
        i_sync_mode_bit && i_global_arch_bit && i_ce |=>
            o_clk_in_data == $past(i_clk_pin) && o_oe_in_data == $past(i_oe_pin);
    endproperty
    a_cplx: assert property (p_cplx) else $error("complex data input wrong");
    property p_simp;
        i_sync_mode_bit && !i_global_arch_bit && i_ce |=> (o_pin_oe_n & (~$past(i_io_config_bit) | 8'h18)) == 8'h00;
    endproperty
    a_simp: assert property (p_simp) else $error("simple drive wrong");
endmodule
bind olm_array olm_array_chk u_chk (.*);

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic i_sync_mode_bit = 1'b0;
    logic i_global_arch_bit = 1'b0;
    logic [7:0] i_polarity_select = 8'h00;
    logic [7:0] i_io_config_bit = 8'h00;
    logic [63:0] i_pt = 64'h0;
    logic i_clk_pin = 1'b0;
    logic i_oe_pin = 1'b0;
    logic i_preload = 1'b0;
    logic [7:0] i_preload_val = 8'h00;
    logic [7:0] i_pin, o_pin, o_pin_oe_n, o_feedback, o_reg_q;
    logic o_clk_in_data, o_oe_in_data;
    logic [1:0] o_mode;
    int err_total = 0;
    int n_checks = 0;
    int seed = 55118;
    int r;
    int eq [8];
    olm_array uut (.*);
    olm_board brd (.i_ref_clk(i_ref_clk), .i_pin_val(o_pin), .i_pin_oe_n(o_pin_oe_n), .o_level(i_pin));
    initial forever #5 i_ref_clk = ~i_ref_clk;
    function automatic logic [7:0] qv();
        for (int n = 0; n < 8; n++) qv[n] = (eq[n] != 0);
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic rise_check();
        for (int n = 0; n < 8; n++) if (!i_io_config_bit[n]) eq[n] = (i_pt[8*n +: 8] != 8'h00);
        i_clk_pin = 1'b1;
        @(negedge i_ref_clk);
        chk("reg_q", qv(), o_reg_q);
        i_clk_pin = 1'b0;
        @(negedge i_ref_clk);
        chk("pin", (qv() ^ ~i_polarity_select) & ~i_io_config_bit, o_pin & ~i_io_config_bit);
        chk("oe_n", {8{i_oe_pin}} & ~i_io_config_bit, o_pin_oe_n & ~i_io_config_bit);
        chk("reg_fb", qv() & ~i_io_config_bit, o_feedback & ~i_io_config_bit);
    endtask
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        err_total++;
        final_report();
    end
    initial begin
        for (int n = 0; n < 8; n++) eq[n] = 0;
        repeat (12) @(negedge i_ref_clk);
        chk("rst_q", 8'h00, o_reg_q);
        chk("rst_oe", 8'hFF, o_pin_oe_n);
        i_nrst = 1'b1;
        for (int m = 0; m < 4; m++) begin
            {i_sync_mode_bit, i_global_arch_bit} = m[1:0];
            @(negedge i_ref_clk);
            chk("mode", (m == 3) ? 8'h01 : (m == 2) ? 8'h02 : 8'h00, {6'h00, o_mode});
        end
        {i_sync_mode_bit, i_global_arch_bit} = 2'h0;
        for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            i_io_config_bit = r[7:0];
            i_polarity_select = r[15:8];
            i_oe_pin = r[16];
            // Three-way AND leaves some cells with no active term
            i_pt = {$random(seed), $random(seed)} & {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
            rise_check();
            i_preload_val = r[31:24];
            i_preload = 1'b1;
            i_clk_pin = r[17];
            @(negedge i_ref_clk);
            for (int n = 0; n < 8; n++) eq[n] = r[24+n];
            i_preload = 1'b0;
            i_clk_pin = 1'b0;
            @(negedge i_ref_clk);
            chk("preload", qv(), o_reg_q);
        end
        i_ce = 1'b0;
        i_clk_pin = 1'b1;
        i_io_config_bit = 8'h00;
        i_pt = '1;
        @(negedge i_ref_clk);
        chk("freeze", qv(), o_reg_q);
        i_ce = 1'b1;
        i_clk_pin = 1'b0;
        {i_sync_mode_bit, i_global_arch_bit} = 2'h3;
        @(negedge i_ref_clk);
        i_clk_pin = 1'b1;
        @(negedge i_ref_clk);
        chk("cplx_q", qv(), o_reg_q);
        chk("clk_data", 8'h01, {7'h00, o_clk_in_data});
        chk("oe_data", {7'h00, i_oe_pin}, {7'h00, o_oe_in_data});
        chk("cplx_oe", 8'h00, o_pin_oe_n & 8'h81);
        chk("cplx_fb", {1'b1, 6'h00, i_oe_pin}, o_feedback & 8'h81);
        {i_sync_mode_bit, i_global_arch_bit} = 2'h2;
        i_io_config_bit = 8'h99;
        repeat (2) @(negedge i_ref_clk);
        chk("simple_oe", 8'h81, o_pin_oe_n);
        chk("simple_fb", 8'h00, o_feedback & 8'h18);
        i_nrst = 1'b0;
        @(negedge i_ref_clk);
        chk("rerst_q", 8'h00, o_reg_q);
        i_nrst = 1'b1;
        final_report();
    end
endmodule
